// *** wdt_params.svh ***
// Timing counts, register indices, field positions and reset values of the watchdog.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WDT_IDX_CTRL 4'h0
`define WDT_IDX_STATUS 4'h1
`define WDT_IDX_GUARD 4'h2
`define WDT_GUARD_KEY 8'h5A
`define WDT_GUARD_CYCLES 4'h4

// ****************************************************************
// Fields
// ****************************************************************
`define WDT_PERIOD_LSB 0
`define WDT_WINDOW_LSB 4
`define WDT_FIELD_W 4
`define WDT_LOCK_BIT 7
`define WDT_BUSY_BIT 0
`define WDT_CTRL_RESET 8'h00
`define WDT_CODE_MAX 4'hB
`define WDT_CODE_OFF 4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define WDT_BASE_CYCLES 14'h0008
`define WDT_CNT_W 14
`define WDT_SYNC_TICKS 2'h2

`endif

// *** wdt_pkg.sv ***
// Types shared by the watchdog modules.
package wdt_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_NORMAL,
        ST_CLOSED,
        ST_OPEN
    } wdt_state_t;
    typedef logic [7:0] cfg_byte_t;
endpackage : wdt_pkg

// *** sync_link_if.sv ***
// Signals between the watchdog core and its oscillator-domain synchroniser.
`timescale 1ns/1ps
interface sync_link_if;
    logic tick;
    logic cfg_wr;
    logic cfg_boot;
    logic [7:0] cfg_data;
    logic [7:0] cfg_eff;
    logic cfg_busy;
    logic clr_req;
    logic clr_busy;
    logic clr_done;
    modport core (output tick, output cfg_wr, output cfg_boot, output cfg_data,
        output clr_req, input cfg_eff, input cfg_busy, input clr_busy, input clr_done);
    modport sync_side (input tick, input cfg_wr, input cfg_boot, input cfg_data,
        input clr_req, output cfg_eff, output cfg_busy, output clr_busy, output clr_done);
endinterface : sync_link_if

// *** cfg_sync.sv ***
// Passes configuration writes and clear requests across on oscillator ticks.
`timescale 1ns/1ps
`include "wdt_params.svh"
module cfg_sync
    import wdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    sync_link_if.sync_side link
);
    cfg_byte_t pend;
    logic [1:0] cfg_cnt;
    logic [1:0] clr_cnt;
    wire cfg_last = cfg_cnt == `WDT_SYNC_TICKS - 2'h1;
    wire clr_last = clr_cnt == `WDT_SYNC_TICKS - 2'h1;

    // ****************************************************************
    // Configuration crossing
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= `WDT_CTRL_RESET;
            link.cfg_eff <= `WDT_CTRL_RESET;
            link.cfg_busy <= 1'b0;
            cfg_cnt <= 2'h0;
        end else if (link.cfg_boot) begin
            link.cfg_eff <= link.cfg_data;
        end else if (link.cfg_wr && !link.cfg_busy) begin
            pend <= link.cfg_data;
            link.cfg_busy <= 1'b1;
            cfg_cnt <= 2'h0;
        end else if (link.cfg_busy && link.tick) begin
            cfg_cnt <= cfg_cnt + 2'h1;
            if (cfg_last) begin
                link.cfg_eff <= pend;
                link.cfg_busy <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Clear crossing
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.clr_busy <= 1'b0;
            link.clr_done <= 1'b0;
            clr_cnt <= 2'h0;
        end else begin
            link.clr_done <= link.clr_busy && link.tick && clr_last;
            if (link.clr_req && !link.clr_busy) begin
                link.clr_busy <= 1'b1;
                clr_cnt <= 2'h0;
            end else if (link.clr_busy && link.tick) begin
                clr_cnt <= clr_cnt + 2'h1;
                if (clr_last) begin
                    link.clr_busy <= 1'b0;
                end
            end
        end
    end

    sequence clr_accepted;
        link.clr_req && !link.clr_busy;
    endsequence

    clr_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        link.clr_busy && !link.clr_done |=> link.clr_busy || link.clr_done)
        else $error("clear synchronisation dropped early");
    clr_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        clr_accepted |=> link.clr_busy && !link.clr_done)
        else $error("accepted clear did not start synchronising");
    cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        link.cfg_wr && !link.cfg_busy && !link.cfg_boot |=> link.cfg_busy && $stable(link.cfg_eff))
        else $error("configuration applied without synchronisation");
endmodule : cfg_sync

// *** wdt_top.sv ***
// Windowed watchdog timer with APB registers, guard unlock and lock bit.
// ****************************************************************
// ****************************************************************
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_top
    import wdt_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic watchdog_osc_clock,
    input wire logic watchdog_clear_instr,
    input wire logic [7:0] boot_config_fuse,
    input wire logic debug_halt,
    input wire logic debug_mode,
    input wire logic reset_ack,
    output logic reset_req
);
    // ****************************************************************
    // Code decoding
    // ****************************************************************
    function automatic logic [`WDT_CNT_W-1:0] code_limit(input logic [3:0] code);
        if (code == `WDT_CODE_OFF || code > `WDT_CODE_MAX) begin
            code_limit = '0;
        end else begin
            code_limit = `WDT_BASE_CYCLES << (code - 4'h1);
        end
    endfunction : code_limit

    sync_link_if link ();
    cfg_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .link(link)
    );

    wdt_state_t state;
    wdt_state_t next_state;
    logic [`WDT_CNT_W-1:0] cnt;
    logic [`WDT_CNT_W-1:0] next_cnt;
    logic osc_q;
    logic lock;
    logic booted;
    logic [3:0] guard_cnt;
    logic halt_q;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
    wire access = psel && penable && !pready;
    wire acc_wr = access && pwrite;
    wire hit_ctrl = idx == (ADDR_W-2)'(`WDT_IDX_CTRL);
    wire hit_status = idx == (ADDR_W-2)'(`WDT_IDX_STATUS);
    wire hit_guard = idx == (ADDR_W-2)'(`WDT_IDX_GUARD);
    wire mapped = (hit_ctrl || hit_status || hit_guard) && paddr[1:0] == 2'h0;
    wire guarded = guard_cnt != 4'h0;
    wire guard_key = acc_wr && hit_guard && pwdata[7:0] == `WDT_GUARD_KEY;
    wire ctrl_ok = acc_wr && hit_ctrl && guarded && !lock && !link.cfg_busy;
    wire status_wr = acc_wr && hit_status && guarded;
    wire lock_set = status_wr && pwdata[`WDT_LOCK_BIT];
    wire lock_clr = status_wr && !pwdata[`WDT_LOCK_BIT] && debug_mode;
    wire [7:0] status_val = {lock, 6'h00, link.cfg_busy};
    wire [7:0] read_val = hit_ctrl ? link.cfg_eff : hit_status ? status_val : 8'h00;

    assign link.cfg_wr = ctrl_ok;
    assign link.cfg_data = booted ? pwdata[7:0] : boot_config_fuse;
    assign link.cfg_boot = !booted;
    assign link.tick = watchdog_osc_clock && !osc_q;
    assign link.clr_req = watchdog_clear_instr;

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= (access && !pwrite && mapped) ? {24'h00_0000, read_val} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_cnt <= 4'h0;
        end else if (guard_key) begin
            guard_cnt <= `WDT_GUARD_CYCLES;
        end else if (ctrl_ok || status_wr) begin
            guard_cnt <= 4'h0;
        end else if (guarded) begin
            guard_cnt <= guard_cnt - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            booted <= 1'b0;
            lock <= 1'b0;
        end else begin
            booted <= 1'b1;
            if (!booted) begin
                lock <= code_limit(boot_config_fuse[3:0]) != '0;
            end else if (lock_set) begin
                lock <= 1'b1;
            end else if (lock_clr) begin
                lock <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    wire [`WDT_CNT_W-1:0] per_lim = code_limit(link.cfg_eff[`WDT_PERIOD_LSB +: `WDT_FIELD_W]);
    wire [`WDT_CNT_W-1:0] win_lim = code_limit(link.cfg_eff[`WDT_WINDOW_LSB +: `WDT_FIELD_W]);
    wire enabled = per_lim != '0;
    wire win_mode = win_lim != '0;
    wire cnt_end = cnt + `WDT_CNT_W'(1) >= (state == ST_CLOSED ? win_lim : per_lim);
    wire clr_hit = link.clr_done && !debug_halt;
    wire clr_fault = clr_hit && state == ST_CLOSED;
    wire time_fault = link.tick && !debug_halt && cnt_end &&
        (state == ST_NORMAL || state == ST_OPEN);
    wire fault = enabled && (clr_fault || time_fault);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        if (!enabled) begin
            next_state = ST_OFF;
            next_cnt = '0;
        end else if (debug_halt) begin
            next_state = ST_NORMAL;
            next_cnt = '0;
        end else if (state == ST_OFF) begin
            next_state = ST_NORMAL;
            next_cnt = '0;
        end else if (clr_hit) begin
            next_state = win_mode ? ST_CLOSED : ST_NORMAL;
            next_cnt = '0;
        end else if (link.tick) begin
            next_cnt = cnt + `WDT_CNT_W'(1);
            if (cnt_end) begin
                next_cnt = '0;
                next_state = state == ST_CLOSED ? ST_OPEN : state;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
            cnt <= '0;
            osc_q <= 1'b0;
            halt_q <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            osc_q <= watchdog_osc_clock;
            halt_q <= debug_halt;
            reset_req <= fault || (reset_req && !reset_ack);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence closed_clear;
        enabled && state == ST_CLOSED && link.clr_done && !debug_halt;
    endsequence

    req_hold_a: assert property (reset_req && !reset_ack |=> reset_req)
        else $error("reset request dropped without acknowledge");
    halt_zero_a: assert property (debug_halt |=> cnt == '0)
        else $error("counter not cleared during halt");
    halt_stop_a: assert property (debug_halt[*2] |-> !reset_req || $past(reset_req))
        else $error("reset requested while halted");
    resume_normal_a: assert property (halt_q && !debug_halt && enabled |-> state == ST_NORMAL)
        else $error("resume did not start a normal period");
    off_idle_a: assert property (!enabled |=> state == ST_OFF && cnt == '0)
        else $error("watchdog running while disabled");
    unguard_a: assert property (acc_wr && !guarded |-> !link.cfg_wr && !lock_set)
        else $error("unguarded write accepted");
    lock_block_a: assert property (lock |-> !link.cfg_wr)
        else $error("control written while locked");
    lock_sticky_a: assert property (lock && !debug_mode |=> lock)
        else $error("lock cleared outside debug");
    closed_clear_a: assert property (closed_clear |=> reset_req)
        else $error("clear in closed period not punished");
    timeout_a: assert property (enabled && state == ST_NORMAL && link.tick && !debug_halt
        && cnt == per_lim - `WDT_CNT_W'(1) |=> reset_req)
        else $error("time-out did not request reset");
    restart_a: assert property (enabled && link.clr_done && !debug_halt && state != ST_OFF
        |=> cnt == '0)
        else $error("clear did not restart the count");
    window_enter_a: assert property (enabled && win_mode && link.clr_done && !debug_halt
        && state == ST_NORMAL |=> state == ST_CLOSED)
        else $error("closed period not started by first clear");
    limit_a: assert property (cnt_end && state == ST_OPEN |-> cnt == per_lim - `WDT_CNT_W'(1))
        else $error("open period length wrong");

    // ****************************************************************
    // Bus, boot and counter checks
    // ****************************************************************
    sequence bus_taken;
        psel && penable && !pready;
    endsequence

    sequence bus_answer;
        pready ##1 !pready;
    endsequence

    sequence req_acked;
        reset_req && reset_ack && !fault;
    endsequence

    answer_next_a: assert property (bus_taken |=> bus_answer)
        else $error("access not answered after one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("slave error outside an answer");
    rdata_quiet_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside an answer");
    wr_rdata_a: assert property (acc_wr |=> prdata == 32'h0000_0000)
        else $error("write answered with read data");
    unmapped_err_a: assert property (access && !mapped |=> pslverr)
        else $error("unmapped access not flagged");
    ctrl_read_a: assert property (access && !pwrite && mapped && hit_ctrl
        |=> prdata == {24'h00_0000, $past(link.cfg_eff)})
        else $error("control read returned wrong value");

    guard_open_a: assert property (guard_key |=> guard_cnt == `WDT_GUARD_CYCLES)
        else $error("guard unlock not opened");
    guard_used_a: assert property (ctrl_ok || status_wr |=> !guarded)
        else $error("guard unlock not consumed");
    boot_load_a: assert property (presetn && !booted
        |=> link.cfg_eff == $past(boot_config_fuse))
        else $error("boot fuse not loaded into control");
    boot_lock_a: assert property (presetn && !booted
        && boot_config_fuse[3:0] != `WDT_CODE_OFF && boot_config_fuse[3:0] <= `WDT_CODE_MAX
        |=> lock)
        else $error("enabled boot did not set lock");

    step_hold_a: assert property (enabled && state != ST_OFF && !link.tick && !clr_hit
        && !debug_halt |=> cnt == $past(cnt))
        else $error("counter moved without an oscillator tick");
    step_one_a: assert property (enabled && state != ST_OFF && link.tick && !clr_hit
        && !debug_halt && !cnt_end |=> cnt == $past(cnt) + `WDT_CNT_W'(1))
        else $error("counter did not advance on a tick");
    open_enter_a: assert property (enabled && state == ST_CLOSED && link.tick && !clr_hit
        && !debug_halt && cnt_end |=> state == ST_OPEN && cnt == '0)
        else $error("closed period not followed by open period");
    open_late_a: assert property (enabled && state == ST_OPEN && link.tick && !debug_halt
        && cnt_end |=> reset_req)
        else $error("missed clear after open period not punished");
    open_clear_a: assert property (enabled && win_mode && state == ST_OPEN && clr_hit
        |=> state == ST_CLOSED)
        else $error("clear in open period did not restart closed period");
    halt_quiet_a: assert property (debug_halt |-> !fault)
        else $error("fault raised while halted");
    normal_clear_a: assert property (enabled && state == ST_NORMAL && clr_hit && !link.tick
        |-> !fault)
        else $error("clear in normal mode raised a fault");
    ack_release_a: assert property (req_acked |=> !reset_req)
        else $error("acknowledged reset request not released");
endmodule : wdt_top

// *** wdt_partner.sv ***
// Reset controller, clear source and oscillator facing the watchdog.
`timescale 1ns/1ps
module wdt_partner #(
    parameter int ACK_WAIT = 6
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr_go,
    input wire logic reset_req,
    output logic watchdog_osc_clock,
    output logic watchdog_clear_instr,
    output logic reset_ack
);
    logic [1:0] div;
    int wait_cnt;
    // ****************************************************************
    // Oscillator, clear pulses and acknowledge
    // ****************************************************************
    assign watchdog_osc_clock = div[1];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 2'h0;
            wait_cnt <= 0;
            watchdog_clear_instr <= 1'b0;
            reset_ack <= 1'b0;
        end else begin
            div <= div + 2'h1;
            watchdog_clear_instr <= clr_go;
            wait_cnt <= reset_req ? wait_cnt + 1 : 0;
            reset_ack <= reset_req && (wait_cnt >= ACK_WAIT);
        end
    end
endmodule : wdt_partner

// *** tb_windowed_watchdog_timer.sv ***
// Self-checking bench of the watchdog over APB.
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc, clr_instr;
    logic clr_go, debug_halt, debug_mode, reset_ack, reset_req, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] fuse;
    int error_cnt, n_compared, cycles, n, i, c;
    wdt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_osc_clock(osc), .watchdog_clear_instr(clr_instr),
        .boot_config_fuse(fuse), .debug_halt(debug_halt), .debug_mode(debug_mode),
        .reset_ack(reset_ack), .reset_req(reset_req));
    wdt_partner partner (.pclk(pclk), .presetn(presetn), .clr_go(clr_go),
        .reset_req(reset_req), .watchdog_osc_clock(osc), .watchdog_clear_instr(clr_instr),
        .reset_ack(reset_ack));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr_g(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, 12'h008, 32'h0000_005A);
        apb(1'b1, a, d);
    endtask : wr_g
    task automatic wait_req(input int mx);
        n = 0;
        while (reset_req !== 1'b1 && n < mx) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_req
    task automatic clear();
        @(posedge pclk);
        clr_go <= 1'b1;
        @(posedge pclk);
        clr_go <= 1'b0;
    endtask : clear
    task automatic rst(input logic [7:0] f);
        @(posedge pclk);
        presetn <= 1'b0;
        fuse <= f;
        debug_halt <= 1'b0;
        debug_mode <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst
    // ****************************************************************
    // Clock, timeout and tests
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 40000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {psel, penable, pwrite, clr_go, debug_halt, debug_mode} = 6'h00;
        {presetn, paddr, pwdata, fuse, error_cnt, n_compared, cycles} = '0;
        rst(8'h00);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_0001);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("Test registers done");
        for (c = 1; c <= 3; c++) begin
            rst(8'h00);
            wr_g(12'h000, c);
            apb(1'b0, 12'h004, 32'h0000_0000);
            chk(rd[0], 1'b1);
            wait_req((32 << (c - 1)) + 40);
            chk({31'h0, n >= (32 << (c - 1)) && n <= (32 << (c - 1)) + 24}, 1);
            repeat (3) @(posedge pclk);
            chk(reset_req, 1'b1);
            wait_req(0);
            repeat (12) @(posedge pclk);
            chk(reset_req, 1'b0);
        end
        $display("Test periods done");
        for (c = 0; c < 2; c++) begin
            rst(8'h00);
            wr_g(12'h000, c ? 32'h0000_000C : 32'h0000_0000);
            wait_req(400);
            chk(n, 400);
        end
        rst(8'h00);
        wr_g(12'h000, 32'h0000_0001);
        for (i = 0; i < 12; i++) begin
            clear();
            wait_req(16);
            chk(n, 16);
        end
        $display("Test clears done");
        rst(8'h00);
        wr_g(12'h000, 32'h0000_0012);
        wait_req(20);
        chk(n, 20);
        clear();
        wait_req(16);
        chk(n, 16);
        clear();
        wait_req(24);
        chk({31'h0, n < 24}, 1);
        rst(8'h00);
        wr_g(12'h000, 32'h0000_0012);
        clear();
        clear();
        wait_req(48);
        clear();
        wait_req(30);
        chk(n, 30);
        $display("Test window done");
        rst(8'h00);
        wr_g(12'h000, 32'h0000_0012);
        wait_req(20);
        debug_halt <= 1'b1;
        wait_req(300);
        chk(n, 300);
        debug_halt <= 1'b0;
        wait_req(80);
        chk({31'h0, n >= 56 && n <= 70}, 1);
        $display("Test debug done");
        rst(8'h00);
        wr_g(12'h004, 32'h0000_0080);
        wr_g(12'h000, 32'h0000_0001);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wr_g(12'h004, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd[7], 1'b1);
        debug_mode <= 1'b1;
        wr_g(12'h004, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd[7], 1'b0);
        rst(8'h01);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd[7], 1'b1);
        $display("Test lock done");
        close_out();
    end
endmodule : tb_windowed_watchdog_timer
